// ---- err_inject_pkg.sv ----
// Package for the payload error injector: register map, fields, stream types
package err_inject_pkg;

   // Register offsets on the byte-wide host port
   localparam logic [7:0] ERROR_RATE_CONTROL_ADDR = 8'hEB;
   localparam logic [7:0] ERROR_COUNT_LOW_ADDR = 8'hEC;
   localparam logic [7:0] ERROR_COUNT_HIGH_ADDR = 8'hED;
   localparam logic [7:0] ERRORS_LEFT_LOW_ADDR = 8'hEE;
   localparam logic [7:0] ERRORS_LEFT_HIGH_ADDR = 8'hEF;

   // Reset values
   localparam logic [7:0] ERROR_RATE_CONTROL_RST = 8'h00;
   localparam logic [7:0] ERROR_COUNT_LOW_RST = 8'h00;
   localparam logic [1:0] ERROR_COUNT_HIGH_RST = 2'h0;
   localparam logic [9:0] ERRORS_LEFT_RST = 10'h000;

   // Field positions in the rate control register
   localparam int RATE_SELECT_LSB = 0;
   localparam int RATE_SELECT_W = 4;
   localparam int CONSTANT_ERROR_BIT = 4;
   localparam int COUNT_LOAD_STROBE_BIT = 7;

   // Error count layout: low register bits 7:0, high register bits 1:0
   localparam int ERROR_COUNT_W = 10;
   localparam int COUNT_HIGH_W = 2;

   // Code 1 selects 1 in 16 = 2**4, so period exponent = code + 3
   localparam int RATE_EXP_OFFSET = 3;
   // Longest period 262,144 = 2**18 counted bits
   localparam int BIT_COUNT_W = 18;

   // One serial payload bit arriving from the framer
   typedef struct packed {
      logic data;        // Bit value
      logic framing;     // Framing bit, never touched or counted
      logic frame_start; // First bit of a frame
      logic chan_sel;    // Bit belongs to a selected timeslot
   } tx_bit_t;

   // One bit leaving toward the line coder
   typedef struct packed {
      logic data;        // Possibly inverted bit
      logic framing;     // Framing bit marker, passed through
      logic frame_start; // Frame start marker, passed through
      logic injected;    // This bit was inverted
   } out_bit_t;

endpackage

// ---- bit_skid_buffer.sv ----
// Two-entry buffer with valid/ready on both sides and registered outputs
`timescale 1ns/100ps
`default_nettype none
module bit_skid_buffer #(
   parameter int WIDTH = 4
) (
   input wire logic sys_clk,           // System clock
   input wire logic reset,             // Synchronous reset, active high
   input wire logic [WIDTH-1:0] in_data, // Word offered
   input wire logic in_valid,          // Word offered this cycle
   output logic in_ready,              // Room for a word (registered)
   output logic [WIDTH-1:0] out_data,  // Head word (registered)
   output logic out_valid,             // Head word valid (registered)
   input wire logic out_ready          // Receiver takes head word
);

   logic [WIDTH-1:0] head_q, head_d, skid_q, skid_d;
   logic head_vld_q, head_vld_d, skid_vld_q, skid_vld_d;
   logic ready_q, ready_d;

   ////////////////////////////////////////////////////////////////////////////
   // Next state: head feeds output, skid catches a word during a stall
   always_comb begin
      head_d = head_q;
      head_vld_d = head_vld_q;
      skid_d = skid_q;
      skid_vld_d = skid_vld_q;
      if (out_ready || !head_vld_q) begin
         // Head drains or empty: refill from skid first, then input
         if (skid_vld_q) begin
            head_d = skid_q;
            head_vld_d = 1'b1;
            skid_vld_d = 1'b0;
            if (in_valid && in_ready) begin
               skid_d = in_data;
               skid_vld_d = 1'b1;
            end
         end else begin
            head_d = in_data;
            head_vld_d = in_valid && in_ready;
         end
      end else if (in_valid && in_ready) begin
         // Stalled head: park the word
         skid_d = in_data;
         skid_vld_d = 1'b1;
      end
      // Ready registered so the port comes straight from a flop
      ready_d = !skid_vld_d;
   end

   // Registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         head_q <= '0;
         head_vld_q <= 1'b0;
         skid_q <= '0;
         skid_vld_q <= 1'b0;
         ready_q <= 1'b1;
      end else begin
         head_q <= head_d;
         head_vld_q <= head_vld_d;
         skid_q <= skid_d;
         skid_vld_q <= skid_vld_d;
         ready_q <= ready_d;
      end
   end

   assign in_ready = ready_q; // Flop output, low when skid occupied
   assign out_data = head_q;
   assign out_valid = head_vld_q;

endmodule
`default_nettype wire

// ---- payload_error_injector.sv ----
// Transmit payload error injector with byte-wide host registers
//
// Contract
// RL1: Four-bit rate code; 0 off, 1..15 give one error per 16 to 262,144.
// RL2: Constant-error flag with nonzero rate ignores count, inserts forever.
// RL3: Constant-error flag clear limits total errors to the loaded count.
// RL4: Rising edge of strobe bit 7 loads count next clock cycle.
// RL5: Host writes both count registers before raising the load strobe.
// RL6: Host clears then sets the strobe for each further count update.
// RL7: Count is 10 bits: low register bits 7:0, high register bits 1:0.
// RL8: Count zero gives none, one gives one, 3FFh gives 1023 errors.
// RL9: Remaining errors readable any time through two read-only registers.
// RL10: Host writes zero to control bits 5 and 6.
// RL11: Remaining value decrements per error, stops at zero, insertion stops.
// RL12: Error made by inverting the last counted bit of each period.
// RL13: Framing bits are never counted and never corrupted.
// RL14: Rate changes take effect only at a frame boundary.
// RL15: Insertion covers whole payload or only selected timeslot channels.
`timescale 1ns/100ps
`default_nettype none
module payload_error_injector
   import err_inject_pkg::*;
(
   input wire logic sys_clk,         // 100 MHz system clock
   input wire logic reset,           // Synchronous reset, active high
   // Host register port
   input wire logic [7:0] reg_addr,  // Register offset
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr,          // Write strobe, one cycle
   input wire logic reg_rd,          // Read strobe, one cycle
   output logic [7:0] reg_rdata,     // Read data, registered
   output logic reg_rvalid,          // Read data valid pulse
   // Payload stream in
   input wire tx_bit_t in_bit,       // Bit from framer
   input wire logic in_valid,        // Bit offered
   output logic in_ready,            // Bit accepted when high with valid
   input wire logic all_channels,    // High: whole payload eligible
   // Payload stream out
   output out_bit_t out_bit,         // Bit toward line side
   output logic out_valid,           // Output bit valid
   input wire logic out_ready        // Receiver takes bit
);

   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] cnt_low_q, cnt_low_d;
   logic [COUNT_HIGH_W-1:0] cnt_high_q, cnt_high_d;
   logic strobe_prev_q, strobe_prev_d;
   logic [ERROR_COUNT_W-1:0] left_q, left_d;
   logic [RATE_SELECT_W-1:0] rate_q, rate_d;
   logic [BIT_COUNT_W-1:0] bits_q, bits_d;
   logic [7:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic accept, eligible, armed, last_bit, inject;
   logic [RATE_SELECT_W-1:0] rate_next;
   out_bit_t stage;

   // Terminal value of the bit counter for a rate code
   function automatic logic [BIT_COUNT_W-1:0] period_last(
      input logic [RATE_SELECT_W-1:0] code
   );
      logic [BIT_COUNT_W:0] one_hot;
      one_hot = (BIT_COUNT_W+1)'(1) << (int'(code) + RATE_EXP_OFFSET);
      period_last = BIT_COUNT_W'(one_hot - (BIT_COUNT_W+1)'(1));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Host writes and reads
   always_comb begin
      ctrl_d = ctrl_q;
      cnt_low_d = cnt_low_q;
      cnt_high_d = cnt_high_q;
      rdata_d = rdata_q;
      rvalid_d = reg_rd;
      if (reg_wr) begin
         unique case (reg_addr)
            // RL10 control stored whole
            ERROR_RATE_CONTROL_ADDR: ctrl_d = reg_wdata;
            // RL7 count split low/high
            ERROR_COUNT_LOW_ADDR: cnt_low_d = reg_wdata;
            ERROR_COUNT_HIGH_ADDR: cnt_high_d = reg_wdata[COUNT_HIGH_W-1:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ERROR_RATE_CONTROL_ADDR: rdata_d = ctrl_q;
            ERROR_COUNT_LOW_ADDR: rdata_d = cnt_low_q;
            ERROR_COUNT_HIGH_ADDR: rdata_d = {6'h00, cnt_high_q};
            // RL9 remaining count readback
            ERRORS_LEFT_LOW_ADDR: rdata_d = left_q[7:0];
            ERRORS_LEFT_HIGH_ADDR: rdata_d = {6'h00, left_q[ERROR_COUNT_W-1:8]};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Insertion decision for the bit being accepted
   always_comb begin
      accept = in_valid && in_ready;
      // RL13 framing bits excluded
      // RL15 whole payload or selected channels
      eligible = !in_bit.framing && (all_channels || in_bit.chan_sel);
      // RL14 rate latched at frame start
      rate_next = (accept && in_bit.frame_start)
         ? ctrl_q[RATE_SELECT_LSB +: RATE_SELECT_W] : rate_q;
      // RL2 constant mode ignores count
      // RL3 count mode needs errors left
      armed = (rate_next != '0)
         && (ctrl_q[CONSTANT_ERROR_BIT] || left_q != '0);
      // RL1 period from rate code
      last_bit = (bits_q == period_last(rate_next))
         || (in_bit.frame_start && period_last(rate_next) == '0);
      // RL12 invert final bit of period
      inject = accept && eligible && armed && last_bit;
      stage.data = in_bit.data ^ inject;
      stage.framing = in_bit.framing;
      stage.frame_start = in_bit.frame_start;
      stage.injected = inject;
   end

   // Counter and remaining-errors next values
   always_comb begin
      rate_d = rate_next;
      bits_d = bits_q;
      left_d = left_q;
      strobe_prev_d = ctrl_q[COUNT_LOAD_STROBE_BIT];
      if (accept && in_bit.frame_start && rate_next != rate_q) begin
         // New rate restarts the period at the boundary
         bits_d = (eligible && rate_next != '0) ? BIT_COUNT_W'(1) : '0;
      end else if (accept && eligible && rate_next != '0) begin
         // RL13 count only payload bits
         bits_d = (bits_q == period_last(rate_next)) ? '0 : bits_q + 1'b1;
      end
      // RL11 decrement, stops at zero
      if (inject && !ctrl_q[CONSTANT_ERROR_BIT] && left_q != '0) begin
         left_d = left_q - 1'b1;
      end
      // RL4 load on strobe rising edge
      // RL8 loaded value is exact count
      if (ctrl_q[COUNT_LOAD_STROBE_BIT] && !strobe_prev_q) begin
         left_d = {cnt_high_q, cnt_low_q};
      end
   end

   // Registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_q <= ERROR_RATE_CONTROL_RST;
         cnt_low_q <= ERROR_COUNT_LOW_RST;
         cnt_high_q <= ERROR_COUNT_HIGH_RST;
         strobe_prev_q <= 1'b0;
         left_q <= ERRORS_LEFT_RST;
         rate_q <= '0;
         bits_q <= '0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         cnt_low_q <= cnt_low_d;
         cnt_high_q <= cnt_high_d;
         strobe_prev_q <= strobe_prev_d;
         left_q <= left_d;
         rate_q <= rate_d;
         bits_q <= bits_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   ////////////////////////////////////////////////////////////////////////////
   // Output buffer so a receiver stall loses no bit
   bit_skid_buffer #(
      .WIDTH($bits(out_bit_t))
   ) out_buf (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_data(stage),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .out_data(out_bit),
      .out_valid(out_valid),
      .out_ready(out_ready)
   );

endmodule
`default_nettype wire

// ---- payload_error_injector_asserts.sv ----
// Port-level assertions for the payload error injector
`timescale 1ns/100ps
`default_nettype none
module payload_error_injector_asserts
   import err_inject_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic reset, // Sync reset
   input wire logic [7:0] reg_addr, // Register offset
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic reg_rvalid, // Read valid
   input wire out_bit_t out_bit, // Bit toward line
   input wire logic out_valid, // Output valid
   input wire logic out_ready // Receiver ready
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Read request of one offset
   sequence s_read_of(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   a_read_answer:
      assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
   a_no_stray_valid:
      assert property (!reg_rd |=> !reg_rvalid) else $error("read valid without read");
   a_rdata_hold:
      assert property (!reg_rvalid && !$past(reset) |-> $stable(reg_rdata))
         else $error("read data moved");
   a_unmapped_zero:
      assert property (reg_rd && !(reg_addr inside {[ERROR_RATE_CONTROL_ADDR:
         ERRORS_LEFT_HIGH_ADDR]}) |=> reg_rdata == 8'h00) else $error("unmapped not zero");
   a_count_high_bits:
      assert property (s_read_of(ERROR_COUNT_HIGH_ADDR) |=> reg_rdata[7:2] == 6'h00)
         else $error("count high spare bits set");
   a_left_high_bits:
      assert property (s_read_of(ERRORS_LEFT_HIGH_ADDR) |=> reg_rdata[7:2] == 6'h00)
         else $error("left high spare bits set");
   a_framing_clean:
      assert property (out_valid && out_bit.framing |-> !out_bit.injected)
         else $error("framing bit corrupted");
   a_stall_hold:
      assert property (out_valid && !out_ready |=> out_valid && $stable(out_bit))
         else $error("output changed in stall");
endmodule
`default_nettype wire

// ---- payload_partner.sv ----
// Framer source and line-side sink around the injector
`timescale 1ns/100ps
`default_nettype none
module payload_partner
   import err_inject_pkg::*;
#(
   parameter int FL = 24
) (
   input wire logic sys_clk, // Clock
   input wire logic reset, // Sync reset
   input wire logic [7:0] frames, // Frames per burst
   input wire logic go, // Start a burst
   input wire logic all_channels, // Whole payload eligible
   output tx_bit_t in_bit, // Bit to injector
   output logic in_valid, // Bit offered
   input wire logic in_ready, // Bit accepted
   input wire out_bit_t out_bit, // Bit from injector
   input wire logic out_valid, // Output valid
   output logic out_ready, // Sink ready
   output logic [15:0] n_out, // Bits received
   output logic [15:0] n_inj, // Inverted bits received
   output logic [15:0] n_bad // Bits that broke the pattern
);
   logic [15:0] left_q, idx_q, cyc_q;
   logic [4:0] pos_in, pos_out;
   logic pat;
   assign pos_in = 5'(idx_q % FL);
   assign pos_out = 5'(n_out % FL);
   assign pat = n_out[0] ^ n_out[3];
   assign in_valid = left_q != 16'h0000;
   // Framing bit leads each frame; data inverted while idle
   assign in_bit = '{data: idx_q[0] ^ idx_q[3] ^ !in_valid, framing: pos_in == 5'h00,
      frame_start: pos_in == 5'h00, chan_sel: pos_in[0]};
   // Sink stalls two cycles in eight
   assign out_ready = cyc_q[2:0] < 3'h6;
   always_ff @(posedge sys_clk) begin
      cyc_q <= cyc_q + 16'h0001;
      if (reset) begin
         cyc_q <= 16'h0000;
         left_q <= 16'h0000;
         idx_q <= 16'h0000;
         n_out <= 16'h0000;
         n_inj <= 16'h0000;
         n_bad <= 16'h0000;
      end else begin
         if (go) begin
            left_q <= 16'(frames * FL);
         end else if (in_valid && in_ready) begin
            left_q <= left_q - 16'h0001;
            idx_q <= idx_q + 16'h0001;
         end
         if (out_valid && out_ready) begin
            n_out <= n_out + 16'h0001;
            n_inj <= n_inj + 16'(out_bit.injected);
            if (out_bit.framing !== (pos_out == 5'h00) || out_bit.data !== (pat ^ out_bit.injected)
               || out_bit.frame_start !== (pos_out == 5'h00)
               || out_bit.injected && (pos_out == 5'h00 || !all_channels && !pos_out[0])) begin
               n_bad <= n_bad + 16'h0001;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb_payload_error_injector.sv ----
// Self-checking bench for the payload error injector
`timescale 1ns/100ps
`default_nettype none
module tb_payload_error_injector;
   import err_inject_pkg::*;
   localparam int FL = 24;
   logic sys_clk, reset, reg_wr, reg_rd, reg_rvalid, all_channels, go;
   logic in_valid, in_ready, out_valid, out_ready;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, frames;
   logic [15:0] n_out, n_inj, n_bad;
   tx_bit_t in_bit;
   out_bit_t out_bit;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   payload_error_injector i_payload_error_injector (.sys_clk(sys_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .in_bit(in_bit), .in_valid(in_valid),
      .in_ready(in_ready), .all_channels(all_channels), .out_bit(out_bit),
      .out_valid(out_valid), .out_ready(out_ready));
   payload_partner #(.FL(FL)) i_payload_partner (.sys_clk(sys_clk), .reset(reset),
      .frames(frames), .go(go), .all_channels(all_channels), .in_bit(in_bit),
      .in_valid(in_valid), .in_ready(in_ready), .out_bit(out_bit), .out_valid(out_valid),
      .out_ready(out_ready), .n_out(n_out), .n_inj(n_inj), .n_bad(n_bad));
   task automatic finish_test();
      if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1 reg_rd = 1'b0;
      check({8'h00, reg_rdata}, {8'h00, e});
   endtask
   // Send whole frames, then compare the inverted-bit count
   task automatic run(input logic [7:0] nf, input logic [15:0] exp_inj);
      logic [15:0] base;
      logic [15:0] tgt;
      base = n_inj;
      tgt = n_out + 16'(nf * FL);
      @(posedge sys_clk);
      #1 frames = nf;
      go = 1'b1;
      @(posedge sys_clk);
      #1 go = 1'b0;
      for (int i = 0; i < 4000 && n_out != tgt; i++) begin
         @(posedge sys_clk);
         #1;
      end
      check(n_out, tgt);
      check(n_inj - base, exp_inj);
      check(n_bad, 16'h0000);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      {reset, reg_wr, reg_rd, go, all_channels} = 5'h11;
      {reg_addr, reg_wdata, frames} = 24'h000000;
      repeat (2) @(posedge sys_clk);
      #1 reset = 1'b0;
      for (int a = 0; a < 5; a++) rc(ERROR_RATE_CONTROL_ADDR + 8'(a), 8'h00);
      rc(8'h10, 8'h00);
      wr(ERRORS_LEFT_LOW_ADDR, 8'h55);
      rc(ERRORS_LEFT_LOW_ADDR, 8'h00);
      wr(ERROR_COUNT_LOW_ADDR, 8'h03);
      wr(ERROR_COUNT_HIGH_ADDR, 8'h00);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h01);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
      rc(ERRORS_LEFT_LOW_ADDR, 8'h03);
      run(8'h0A, 16'h0003);
      rc(ERRORS_LEFT_LOW_ADDR, 8'h00);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h12);
      run(8'h08, 16'h0005);
      all_channels = 1'b0;
      wr(ERROR_RATE_CONTROL_ADDR, 8'h11);
      run(8'h08, 16'h0006);
      all_channels = 1'b1;
      wr(ERROR_RATE_CONTROL_ADDR, 8'h10);
      run(8'h04, 16'h0000);
      wr(ERROR_COUNT_LOW_ADDR, 8'h00);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h01);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
      run(8'h02, 16'h0000);
      wr(ERROR_COUNT_LOW_ADDR, 8'hFF);
      wr(ERROR_COUNT_HIGH_ADDR, 8'hFF);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h01);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
      rc(ERRORS_LEFT_LOW_ADDR, 8'hFF);
      rc(ERRORS_LEFT_HIGH_ADDR, 8'h03);
      rc(ERROR_COUNT_HIGH_ADDR, 8'h03);
      // no reload without a falling strobe
      wr(ERROR_COUNT_LOW_ADDR, 8'h05);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
      rc(ERRORS_LEFT_LOW_ADDR, 8'hFF);
      wr(ERROR_COUNT_HIGH_ADDR, 8'h00);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h01);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
      rc(ERRORS_LEFT_LOW_ADDR, 8'h05);
      rc(ERRORS_LEFT_HIGH_ADDR, 8'h00);
      run(8'h04, 16'h0005);
      rc(ERRORS_LEFT_LOW_ADDR, 8'h00);
      wr(ERROR_COUNT_LOW_ADDR, 8'h01);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h01);
      wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
      run(8'h02, 16'h0001);
      finish_test();
   end
endmodule
bind payload_error_injector payload_error_injector_asserts i_payload_error_injector_asserts (
   .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .out_bit(out_bit), .out_valid(out_valid),
   .out_ready(out_ready));
`default_nettype wire
